// ===== bench/mcet_useq_model.sv
// Microsequencer model: click phases and ordering of micro-operations
`timescale 1ns/1ps
module mcet_useq_model (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_rd,
  input wire logic i_mw,
  input wire logic i_last,
  output logic [1:0] o_click_phase,
  output logic [3:0] o_rd,
  output logic o_mw
);
  logic late_q;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_click_phase <= 2'h0;
      late_q <= 1'b0;
    end else begin
      o_click_phase <= (o_click_phase == 2'h3) ? 2'h1 : o_click_phase + 2'h1;
      late_q <= (|o_rd) && (o_click_phase != 2'h1);
    end
  end
  // Closing click never reads the buffer late
  assign o_rd = (i_last && o_click_phase != 2'h1) ? 4'h0 : i_rd;
  // Address may hang on an unchecked byte, so no write right after
  assign o_mw = i_mw && !late_q;
endmodule // mcet_useq_model

// ===== bench/microcode_error_trap_test.sv
// Self-checking bench of the microcode error trap block
`timescale 1ns/1ps
module microcode_error_trap_test;
  logic clk, rstn, push, xp, zp, mw_req, mw, refill, boot_n, clr_n, go;
  logic misc, stat, psel, pen, pwr, trap, rtrap, mdrw, mclr, oe, irq;
  logic pready, pslverr, serr;
  logic [1:0] ph, fill, err_n;
  logic [3:0] rd_req, rd, ptr;
  logic [11:0] paddr;
  logic [12:0] na, na_o, na1, na2;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] stk [12] = '{3'h2, 3'h4, 3'h3, 3'h5, 3'h6, 3'h4, 3'h4, 3'h3,
                           3'h4, 3'h7, 3'h1, 3'h5};
  int miscompares, comparisons, mptr, code, sts, seed;

  mcet_useq_model i_mcet_useq_model (.i_core_clk(clk), .i_rstn(rstn),
    .i_rd(rd_req), .i_mw(mw_req), .i_last(1'b0), .o_click_phase(ph),
    .o_rd(rd), .o_mw(mw));

  mcet_trap_core i_mcet_trap_core (.i_core_clk(clk), .i_rstn(rstn),
    .i_click_phase(ph), .i_push(push), .i_x_field_pop(xp),
    .i_z_field_pop(zp), .i_buffer_fill_state(fill),
    .i_buffer_byte_read(rd[0]), .i_buffer_read_no_advance(rd[1]),
    .i_buffer_low_nibble_read(rd[2]), .i_buffer_high_nibble_read(rd[3]),
    .i_memory_data_write(mw), .i_refill_trap_req(refill),
    .i_boot_exit_trap_n(boot_n), .i_trap_clear_n(clr_n),
    .i_misc_read_cmd(misc), .i_interrupt_status_read_cmd(stat),
    .i_next_addr(na), .o_trap(trap), .o_next_addr(na_o),
    .o_refill_trap(rtrap), .o_mdr_write(mdrw), .o_macro_int_clear(mclr),
    .o_xbus_err_n(err_n), .o_xbus_err_oe(oe), .o_operand_stack_ptr(ptr),
    .o_irq(irq), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic int xs(int s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Random next address each cycle; forced to zero by a trap
  always @(posedge clk) begin
    if (go) chk({19'h0, na_o}, trap ? 32'h0 : {19'h0, na2});
    na2 = na1;
    seed = xs(seed);
    na1 = seed[12:0];
    na <= na1;
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) miscompares++;
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic clear();
    clr_n <= 1'b0;
    @(posedge clk);
    clr_n <= 1'b1;
    @(posedge clk);
    chk(mclr, 1);
    code = 0;
    repeat (2) @(posedge clk);
    chk(err_n, 2'h3);
  endtask

  // op: [10] keep code, [9] boot exit, [8] write next cycle, [7] refill,
  // [6:3] buffer reads, [2] push, [1] x pop, [0] z pop
  task automatic run(input int p, input logic [10:0] op,
                     input logic [1:0] f);
    int n, d, nc, se, be, e, em;
    case (op[2:0])
      3'b100: begin d = 1; se = mptr == 15; end
      3'b010, 3'b001: begin d = -1; se = mptr == 0; end
      3'b110: begin d = 0; se = mptr == 15; end
      3'b101: begin d = 0; se = mptr == 0; end
      3'b011: begin d = -1; se = mptr < 2; end
      3'b111: begin d = 0; se = mptr < 2; end
      default: begin d = 0; se = 0; end
    endcase
    be = (|op[6:3]) && f == mcet_pkg::FILL_EMPTY;
    nc = op[9] ? 1 : se ? 2 : be ? 3 : 0;
    if (nc != 0 && (code == 0 || nc < code)) code = nc;
    sts |= int'(op[9]) << mcet_pkg::EV_INIT;
    sts |= se << mcet_pkg::EV_STACK;
    sts |= be << mcet_pkg::EV_IB;
    mptr = (mptr + d) & 15;
    e = (op[9] || se) ? (p == 1 ? 3 : 4 - p) : be ? (p == 1 ? 3 : 7 - p) : 0;
    em = op[8] && !(be && p == 1) && !((|op[6:3]) && p != 1);
    @(posedge clk);
    while (ph !== (p == 1 ? 2'h3 : 2'(p - 1))) @(posedge clk);
    {boot_n, refill, rd_req, push, xp, zp} <= {~op[9], op[7:0]};
    fill <= f;
    @(posedge clk);
    {boot_n, refill, rd_req, push, xp, zp} <= 9'h100;
    mw_req <= op[8];
    n = 0;
    for (int i = 1; i <= 12; i++) begin
      @(posedge clk);
      if (i == 1) mw_req <= 1'b0;
      if (i == 1) chk(rtrap, op[7] && !(se || be || op[9]));
      if (i == 2) chk(mdrw, em);
      if (trap === 1'b1 && n == 0) n = i;
    end
    chk(n, e);
    chk(ptr, mptr);
    misc <= p[0];
    stat <= !p[0];
    @(posedge clk);
    misc <= 1'b0;
    stat <= 1'b0;
    @(posedge clk);
    chk({oe, err_n}, {1'b1, ~code[1:0]});
    if (!op[10]) clear();
    $display("test done: phase %0d op %h", p, op);
  endtask

  initial begin
    #(40 * 5000);
    miscompares++;
    results();
  end

  initial begin
    {rstn, go, push, xp, zp, mw_req, refill, misc, stat} = '0;
    {psel, pen, pwr, boot_n, clr_n} = 5'h3;
    fill = 2'h3;
    rd_req = 4'h0;
    paddr = '0;
    pwdata = '0;
    na = '0;
    {na1, na2} = '0;
    {miscompares, comparisons, mptr, code, sts} = '0;
    seed = 41;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    go <= 1'b1;
    chk({trap, err_n, ptr}, {1'b0, 2'h3, 4'h0});
    foreach (stk[i]) run(i % 3 + 1, {8'h0, stk[i]}, 2'h3);
    for (int r = 0; r < 4; r++)
      run(r % 3 + 1, {4'h3, 4'h1 << r, 3'h0}, mcet_pkg::FILL_EMPTY);
    run(2, 11'h008, 2'h2);
    run(1, 11'h080, 2'h3);
    run(1, 11'h088, mcet_pkg::FILL_EMPTY);
    run(2, 11'h100, 2'h3);
    run(2, 11'h200, 2'h3);
    run(3, 11'h201, 2'h3);
    run(1, 11'h404, 2'h3);
    run(2, 11'h408, mcet_pkg::FILL_EMPTY);
    run(3, 11'h600, 2'h3);
    apb(1'b0, mcet_pkg::REG_MASK, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, mcet_pkg::REG_STATUS, 32'h0);
    chk(rdat, sts);
    chk(irq, 1'b0);
    apb(1'b1, mcet_pkg::REG_MASK, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b0, mcet_pkg::REG_TRAP, 32'h0);
    chk(rdat & 32'hf3, {24'h0, mptr[3:0], 2'h0, code[1:0]});
    apb(1'b1, mcet_pkg::REG_STATUS, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(serr, 1'b1);
    chk(rdat, 32'h0);
    clear();
    $display("test done: registers and interrupt");
    results();
  end
endmodule // microcode_error_trap_test

// ===== verilog/mcet_pkg.sv
// Constants and types of the microcode error trap block
// ----------------------------------------------------------------------
// How it works
// - Stack boundary op traps to location 0 at c1, pointer still moves
// - Lone pop: -1, underflow at 0; lone push: +1, overflow at 15
// - Both field pops: underflow at 0 or 1; all three keep pointer
// - Any buffer read while fill state is empty raises buffer-empty trap
// - Buffer-empty error in c1 cancels memory write of next cycle
// - Error in c1 traps at next c1; buffer-empty in c2/c3 runs one extra click first
// - Boot exit pulse traps to location 0 and is held as error code 1
// - Active-low clear strobe resets the just-handled error trap
// - Trap output forces next control-store address to bank 0, loc 0
// - Active-low code bits go to X bus 08/09 on misc or status read
// - Code 1 init, 2 stack, 3 buffer-empty, 0 unused; lower wins
// - Error traps cannot be masked and beat buffer refill traps
// - Trap clear also clears pending macroinstruction interrupt
// ----------------------------------------------------------------------
package mcet_pkg;
  // Stack pointer
  localparam int unsigned PTR_W = 4;
  localparam logic [PTR_W-1:0] PTR_TOP = 4'hf;
  localparam logic [PTR_W-1:0] PTR_BOTTOM = 4'h0;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
  // Buffer fill state encoding for empty
  localparam logic [1:0] FILL_EMPTY = 2'h0;
  // Error codes, lower value has priority
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_INIT = 2'h1;
  localparam logic [1:0] CODE_STACK = 2'h2;
  localparam logic [1:0] CODE_IBEMPTY = 2'h3;
  // Next address width: bank bit plus 12-bit location
  localparam int unsigned NA_W = 13;
  localparam logic [NA_W-1:0] TRAP_ADDR = 13'h0000;
  // APB register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] REG_MASK = 12'h004;
  localparam logic [ADDR_W-1:0] REG_TRAP = 12'h008;
  // Event bits in status and mask
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EV_INIT = 0;
  localparam int unsigned EV_STACK = 1;
  localparam int unsigned EV_IB = 2;
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
  // Trap info register fields
  localparam int unsigned TF_CODE = 0;
  localparam int unsigned TF_PEND = 2;
  localparam int unsigned TF_DEFER = 3;
  localparam int unsigned TF_PTR = 4;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_C1 = 2'b01,
    PH_C2 = 2'b10,
    PH_C3 = 2'b11
  } mcet_phase_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ARMED = 2'b01,
    S_DEFER = 2'b10
  } mcet_sched_e;
endpackage

// ===== verilog/mcet_stack_unit.sv
// Operand stack pointer with overflow and underflow detection
`timescale 1ns/1ps
module mcet_stack_unit (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  mcet_stk_if.unit stk
);
  logic [mcet_pkg::PTR_W-1:0] ptr_q;
  logic [mcet_pkg::PTR_W-1:0] ptr_d;
  logic err;
  logic at_top;
  logic at_bot;
  logic low_two;

  // ----------------------------------------------------------------
  // Next pointer and boundary check
  // ----------------------------------------------------------------
  always_comb begin
    at_top = (ptr_q == mcet_pkg::PTR_TOP);
    at_bot = (ptr_q == mcet_pkg::PTR_BOTTOM);
    low_two = at_bot || (ptr_q == mcet_pkg::PTR_ONE);
    ptr_d = ptr_q;
    err = 1'b0;
    case ({stk.push, stk.x_pop, stk.z_pop})
      3'b100: begin
        ptr_d = ptr_q + mcet_pkg::PTR_ONE;
        err = at_top;
      end
      3'b010, 3'b001: begin
        ptr_d = ptr_q - mcet_pkg::PTR_ONE;
        err = at_bot;
      end
      3'b110: err = at_top;
      3'b101: err = at_bot;
      // Two pops count double for underflow
      3'b011: begin
        ptr_d = ptr_q - mcet_pkg::PTR_ONE;
        err = low_two;
      end
      3'b111: err = low_two;
      default: ptr_d = ptr_q;
    endcase
  end

  // Pointer moves even when the op traps
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr_q <= mcet_pkg::PTR_RST;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign stk.ptr = ptr_q;
  assign stk.bound_err = err;

  property p_push_top;
    @(posedge i_core_clk) disable iff (!i_rstn)
    ({stk.push, stk.x_pop, stk.z_pop} == 3'b100) && ptr_q == 4'hf
    |-> stk.bound_err ##1 ptr_q == 4'h0;
  endproperty
  a_push_top: assert property (p_push_top)
    else $error("push at top did not overflow and wrap");

  property p_pop_bottom;
    @(posedge i_core_clk) disable iff (!i_rstn)
    ({stk.push, stk.x_pop, stk.z_pop} == 3'b010) && ptr_q == 4'h0
    |-> stk.bound_err ##1 ptr_q == 4'hf;
  endproperty
  a_pop_bottom: assert property (p_pop_bottom)
    else $error("pop at bottom did not underflow and wrap");

  property p_triple;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (stk.push && stk.x_pop && stk.z_pop)
    |-> (stk.bound_err == (ptr_q <= 4'h1)) ##1 $stable(ptr_q);
  endproperty
  a_triple: assert property (p_triple)
    else $error("triple op moved pointer or misjudged underflow");
endmodule // mcet_stack_unit

// ===== verilog/mcet_stk_if.sv
// Interface between trap core and stack pointer unit
`timescale 1ns/1ps
interface mcet_stk_if;
  logic push;
  logic x_pop;
  logic z_pop;
  logic [mcet_pkg::PTR_W-1:0] ptr;
  logic bound_err;
  modport ctl (output push, output x_pop, output z_pop,
               input ptr, input bound_err);
  modport unit (input push, input x_pop, input z_pop,
                output ptr, output bound_err);
endinterface

// ===== verilog/mcet_trap_core.sv
// Error trap machine: detection, scheduling, code hold and APB access
`timescale 1ns/1ps
module mcet_trap_core (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Micro-operation inputs
  input wire logic [1:0] i_click_phase,
  input wire logic i_push,
  input wire logic i_x_field_pop,
  input wire logic i_z_field_pop,
  input wire logic [1:0] i_buffer_fill_state,
  input wire logic i_buffer_byte_read,
  input wire logic i_buffer_read_no_advance,
  input wire logic i_buffer_low_nibble_read,
  input wire logic i_buffer_high_nibble_read,
  input wire logic i_memory_data_write,
  input wire logic i_refill_trap_req,
  input wire logic i_boot_exit_trap_n,
  input wire logic i_trap_clear_n,
  input wire logic i_misc_read_cmd,
  input wire logic i_interrupt_status_read_cmd,
  input wire logic [12:0] i_next_addr,
  // Sequencer and data path outputs
  output logic o_trap,
  output logic [12:0] o_next_addr,
  output logic o_refill_trap,
  output logic o_mdr_write,
  output logic o_macro_int_clear,
  output logic [1:0] o_xbus_err_n,
  output logic o_xbus_err_oe,
  output logic [3:0] o_operand_stack_ptr,
  output logic o_irq,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  mcet_stk_if stk ();

  logic ib_err;
  logic init_evt;
  logic clr;
  logic [mcet_pkg::EVT_W-1:0] evt;
  mcet_pkg::mcet_phase_e ph;

  mcet_pkg::mcet_sched_e sched_q;
  mcet_pkg::mcet_sched_e sched_d;
  logic [1:0] code_q;
  logic [1:0] code_d;
  logic trap_q;
  logic trap_d;
  logic [12:0] na_q;
  logic [12:0] na_d;
  logic supp_q;
  logic supp_d;
  logic mdr_q;
  logic mdr_d;
  logic refill_q;
  logic refill_d;
  logic mint_q;
  logic mint_d;
  logic [1:0] xb_q;
  logic [1:0] xb_d;
  logic xoe_q;
  logic xoe_d;
  logic [3:0] ptr_q;

  logic [mcet_pkg::EVT_W-1:0] stat_q;
  logic [mcet_pkg::EVT_W-1:0] stat_d;
  logic [mcet_pkg::EVT_W-1:0] mask_q;
  logic [mcet_pkg::EVT_W-1:0] mask_d;
  logic irq_q;
  logic irq_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rdy_q;
  logic rdy_d;
  logic err_q;
  logic err_d;

  // Lowest code among events wins
  function automatic logic [1:0] pick_code(
    input logic [mcet_pkg::EVT_W-1:0] e
  );
    logic [1:0] c;
    c = mcet_pkg::CODE_NONE;
    if (e[mcet_pkg::EV_INIT]) begin
      c = mcet_pkg::CODE_INIT;
    end else if (e[mcet_pkg::EV_STACK]) begin
      c = mcet_pkg::CODE_STACK;
    end else if (e[mcet_pkg::EV_IB]) begin
      c = mcet_pkg::CODE_IBEMPTY;
    end
    return c;
  endfunction

  function automatic logic map_hit(input logic [11:0] a);
    return (a == mcet_pkg::REG_STATUS) || (a == mcet_pkg::REG_MASK) ||
           (a == mcet_pkg::REG_TRAP);
  endfunction

  mcet_stack_unit u_stack (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .stk(stk.unit)
  );

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  assign stk.push = i_push;
  assign stk.x_pop = i_x_field_pop;
  assign stk.z_pop = i_z_field_pop;
  assign ph = mcet_pkg::mcet_phase_e'(i_click_phase);
  assign ib_err = (i_buffer_byte_read || i_buffer_read_no_advance ||
                   i_buffer_low_nibble_read || i_buffer_high_nibble_read) &&
                  (i_buffer_fill_state == mcet_pkg::FILL_EMPTY);
  assign init_evt = !i_boot_exit_trap_n;
  assign clr = !i_trap_clear_n;
  assign evt = {ib_err, stk.bound_err, init_evt};

  // ----------------------------------------------------------------
  // Trap scheduling and code hold
  // ----------------------------------------------------------------
  // Trap fires at c3 so the registered output covers the next c1.
  always_comb begin
    logic [1:0] base;
    logic [1:0] cand;
    logic pend;
    logic defer;
    base = clr ? mcet_pkg::CODE_NONE : code_q;
    cand = pick_code(evt);
    pend = (!clr && sched_q != mcet_pkg::S_IDLE) || (|evt);
    defer = (!clr && sched_q == mcet_pkg::S_DEFER) ||
            (ib_err && ph != mcet_pkg::PH_C1);
    code_d = base;
    if (|evt && (base == mcet_pkg::CODE_NONE || cand < base)) begin
      code_d = cand;
    end
    trap_d = 1'b0;
    sched_d = mcet_pkg::S_IDLE;
    case ({pend, defer})
      2'b10: begin
        if (ph == mcet_pkg::PH_C3) begin
          trap_d = 1'b1;
        end else begin
          sched_d = mcet_pkg::S_ARMED;
        end
      end
      // Deferred trap lets one extra click run first
      2'b11: begin
        sched_d = (ph == mcet_pkg::PH_C3) ? mcet_pkg::S_ARMED
                                          : mcet_pkg::S_DEFER;
      end
      default: sched_d = mcet_pkg::S_IDLE;
    endcase
    na_d = trap_d ? mcet_pkg::TRAP_ADDR : i_next_addr;
    supp_d = ib_err && ph == mcet_pkg::PH_C1;
    mdr_d = i_memory_data_write && !supp_q;
    // Errors cannot be masked and cancel a refill trap
    refill_d = i_refill_trap_req && !trap_d && !pend;
    mint_d = clr;
    xoe_d = i_misc_read_cmd || i_interrupt_status_read_cmd;
    xb_d = ~code_q;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sched_q <= mcet_pkg::S_IDLE;
      code_q <= mcet_pkg::CODE_NONE;
      trap_q <= 1'b0;
      na_q <= mcet_pkg::TRAP_ADDR;
      supp_q <= 1'b0;
      mdr_q <= 1'b0;
      refill_q <= 1'b0;
      mint_q <= 1'b0;
      xb_q <= ~mcet_pkg::CODE_NONE;
      xoe_q <= 1'b0;
      ptr_q <= mcet_pkg::PTR_RST;
    end else begin
      sched_q <= sched_d;
      code_q <= code_d;
      trap_q <= trap_d;
      na_q <= na_d;
      supp_q <= supp_d;
      mdr_q <= mdr_d;
      refill_q <= refill_d;
      mint_q <= mint_d;
      xb_q <= xb_d;
      xoe_q <= xoe_d;
      ptr_q <= stk.ptr;
    end
  end

  // ----------------------------------------------------------------
  // APB registers and interrupt
  // ----------------------------------------------------------------
  // One wait state keeps read data and answer straight from flops.
  always_comb begin
    logic acc;
    logic wr;
    acc = i_psel && i_penable && rdy_q;
    wr = acc && i_pwrite && map_hit(i_paddr);
    rdy_d = i_psel && i_penable && !rdy_q;
    err_d = rdy_d && !map_hit(i_paddr);
    rdata_d = 32'h0000_0000;
    if (rdy_d && !i_pwrite) begin
      case (i_paddr)
        mcet_pkg::REG_STATUS: rdata_d[mcet_pkg::EVT_W-1:0] = stat_q;
        mcet_pkg::REG_MASK: rdata_d[mcet_pkg::EVT_W-1:0] = mask_q;
        mcet_pkg::REG_TRAP: begin
          rdata_d[mcet_pkg::TF_CODE +: 2] = code_q;
          rdata_d[mcet_pkg::TF_PEND] = (sched_q != mcet_pkg::S_IDLE);
          rdata_d[mcet_pkg::TF_DEFER] = (sched_q == mcet_pkg::S_DEFER);
          rdata_d[mcet_pkg::TF_PTR +: 4] = ptr_q;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr && i_paddr == mcet_pkg::REG_MASK) begin
      mask_d = i_pwdata[mcet_pkg::EVT_W-1:0];
    end
    if (wr && i_paddr == mcet_pkg::REG_STATUS) begin
      stat_d = stat_q & ~i_pwdata[mcet_pkg::EVT_W-1:0];
    end
    // New event wins over a same-cycle clear
    stat_d = stat_d | evt;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_q <= '0;
      mask_q <= mcet_pkg::MASK_RST;
      irq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  assign o_trap = trap_q;
  assign o_next_addr = na_q;
  assign o_refill_trap = refill_q;
  assign o_mdr_write = mdr_q;
  assign o_macro_int_clear = mint_q;
  assign o_xbus_err_n = xb_q;
  assign o_xbus_err_oe = xoe_q;
  assign o_operand_stack_ptr = ptr_q;
  assign o_irq = irq_q;
  assign o_prdata = rdata_q;
  assign o_pready = rdy_q;
  assign o_pslverr = err_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_stack_trap;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (stk.bound_err && ph == mcet_pkg::PH_C1 && i_trap_clear_n &&
     sched_q == mcet_pkg::S_IDLE && !ib_err)
    ##1 (ph == mcet_pkg::PH_C2 && i_trap_clear_n && !ib_err)
    ##1 (ph == mcet_pkg::PH_C3 && i_trap_clear_n && !ib_err)
    |=> o_trap;
  endproperty
  a_stack_trap: assert property (p_stack_trap)
    else $error("stack error in c1 did not trap at next c1");

  property p_ib_code;
    @(posedge i_core_clk) disable iff (!i_rstn)
    ib_err |=> code_q != 2'h0 && stat_q[2];
  endproperty
  a_ib_code: assert property (p_ib_code)
    else $error("buffer read while empty not recorded");

  property p_mdr_cancel;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (ib_err && ph == mcet_pkg::PH_C1) ##1 i_memory_data_write
    |=> !o_mdr_write;
  endproperty
  a_mdr_cancel: assert property (p_mdr_cancel)
    else $error("memory write not cancelled after c1 buffer error");

  property p_ib_defer;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (ib_err && ph == mcet_pkg::PH_C2 && sched_q == mcet_pkg::S_IDLE &&
     i_trap_clear_n) ##1 (ph == mcet_pkg::PH_C3 && i_trap_clear_n)
    |=> !o_trap;
  endproperty
  a_ib_defer: assert property (p_ib_defer)
    else $error("late buffer error trapped without extra click");

  property p_init;
    @(posedge i_core_clk) disable iff (!i_rstn)
    !i_boot_exit_trap_n
    |=> code_q == mcet_pkg::CODE_INIT &&
        (sched_q != mcet_pkg::S_IDLE || o_trap);
  endproperty
  a_init: assert property (p_init)
    else $error("boot exit did not arm a code 1 trap");

  property p_clear;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (!i_trap_clear_n && evt == 3'h0)
    |=> code_q == 2'h0 && sched_q == mcet_pkg::S_IDLE && o_macro_int_clear;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear strobe left trap state or interrupt");

  property p_addr;
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_trap |-> o_next_addr == 13'h0000 && !o_refill_trap;
  endproperty
  a_addr: assert property (p_addr)
    else $error("trap did not force address zero");

  property p_xbus;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_misc_read_cmd || i_interrupt_status_read_cmd)
    |=> o_xbus_err_oe && o_xbus_err_n == ~$past(code_q);
  endproperty
  a_xbus: assert property (p_xbus)
    else $error("error code not driven on read command");

  property p_refill;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_refill_trap_req && |evt) |=> !o_refill_trap;
  endproperty
  a_refill: assert property (p_refill)
    else $error("refill trap not suppressed by error");

  property p_hold;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (code_q != 2'h0 && i_trap_clear_n)
    |=> code_q != 2'h0 && code_q <= $past(code_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held error code lost or lowered in priority");
endmodule // mcet_trap_core
